// >>> cbbx_params.svh
// Constants for the conditional bit branch execution block
`ifndef CBBX_PARAMS_SVH
`define CBBX_PARAMS_SVH
`define CBBX_OP_BIT_BRANCH 8'h10
`define CBBX_OP_CARRY_BRANCH 8'h40
`define CBBX_LEN_BIT_BRANCH 16'h0003
`define CBBX_LEN_CARRY_BRANCH 16'h0002
`define CBBX_PC_RESET 16'h0000
`define CBBX_EXEC_CYCLES 2'h2
`endif

// >>> cbbx_pkg.sv
// Types for the conditional bit branch execution block
package cbbx_pkg;
  typedef enum logic [1:0] {
    CBBX_IDLE,
    CBBX_EXEC,
    CBBX_DONE
  } cbbx_state_e;
  typedef logic [15:0] cbbx_addr_t;
endpackage

// >>> cbbx_target.sv
// Branch target adder: advanced counter plus sign-extended displacement
`timescale 1ns/1ns
`include "cbbx_params.svh"
module cbbx_target
  import cbbx_pkg::*;
#(
  parameter int AW = 16
) (
  // Operands
  input wire logic [AW-1:0] pc_i,
  input wire logic is_bit_i,
  input wire logic [7:0] disp_i,
  // Results
  output logic [AW-1:0] advanced_o,
  output logic [AW-1:0] target_o
);
  logic [AW-1:0] step;
  always_comb begin
    // Bit branch is three bytes long, carry branch two
    step = is_bit_i ? AW'(`CBBX_LEN_BIT_BRANCH) : AW'(`CBBX_LEN_CARRY_BRANCH);
    advanced_o = AW'(pc_i + step);
    // Add to the advanced value, not the opcode address
    target_o = AW'(advanced_o + {{(AW-8){disp_i[7]}}, disp_i});
  end
endmodule // cbbx_target

// >>> cbbx_exec.sv
// Execution of the bit-set-clear branch and the carry-set branch
`timescale 1ns/1ns
`include "cbbx_params.svh"
module cbbx_exec
  import cbbx_pkg::*;
#(
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Decoded instruction
  input wire logic START_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic [7:0] BIT_ADDR_I,
  input wire logic [7:0] DISP_I,
  input wire logic [AW-1:0] PC_I,
  // Core state
  input wire logic BIT_VAL_I,
  input wire logic CARRY_I,
  input wire logic [7:0] PSW_I,
  // Program counter update
  output logic PC_WE_O,
  output logic [AW-1:0] PC_O,
  // Bit write-back
  output logic BIT_WE_O,
  output logic [7:0] BIT_ADDR_O,
  output logic BIT_DATA_O,
  // Flags and status
  output logic PSW_WE_O,
  output logic [7:0] PSW_O,
  output logic BUSY_O,
  output logic TAKEN_O,
  output logic ILLEGAL_O
);
  cbbx_state_e state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic is_bit_r, is_bit_nxt;
  logic cond_r, cond_nxt;
  logic [7:0] disp_r, disp_nxt;
  logic [7:0] baddr_r, baddr_nxt;
  logic [AW-1:0] pc_base_r, pc_base_nxt;
  logic pc_we_r, pc_we_nxt;
  logic [AW-1:0] pc_r, pc_nxt;
  logic bit_we_r, bit_we_nxt;
  logic taken_r, taken_nxt;
  logic illegal_r, illegal_nxt;
  logic [7:0] psw_r, psw_nxt;
  logic busy_r, busy_nxt;
  logic bit_data_r, bit_data_nxt;
  logic psw_we_r, psw_we_nxt;
  logic [AW-1:0] advanced, target;
  logic is_bit_op, is_carry_op;

  assign is_bit_op = (OPCODE_I == `CBBX_OP_BIT_BRANCH);
  assign is_carry_op = (OPCODE_I == `CBBX_OP_CARRY_BRANCH);

  cbbx_target #(.AW(AW)) u_target (
    .pc_i(pc_base_r),
    .is_bit_i(is_bit_r),
    .disp_i(disp_r),
    .advanced_o(advanced),
    .target_o(target)
  );

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    is_bit_nxt = is_bit_r;
    cond_nxt = cond_r;
    disp_nxt = disp_r;
    baddr_nxt = baddr_r;
    pc_base_nxt = pc_base_r;
    pc_we_nxt = 1'b0;
    pc_nxt = pc_r;
    bit_we_nxt = 1'b0;
    taken_nxt = taken_r;
    illegal_nxt = 1'b0;
    // Write-back data is always zero, flags are never written
    bit_data_nxt = 1'b0;
    psw_we_nxt = 1'b0;
    // Flags are passed through untouched; write strobe never raised
    psw_nxt = PSW_I;
    case (state_r)
      CBBX_IDLE: begin
        if (START_I) begin
          if (is_bit_op || is_carry_op) begin
            is_bit_nxt = is_bit_op;
            // Condition sampled at issue: bit value or carry
            cond_nxt = is_bit_op ? BIT_VAL_I : (CARRY_I == 1'b1);
            disp_nxt = DISP_I;
            baddr_nxt = BIT_ADDR_I;
            pc_base_nxt = PC_I;
            cnt_nxt = 2'h1;
            state_nxt = CBBX_EXEC;
          end else begin
            illegal_nxt = 1'b1;
          end
        end
      end
      CBBX_EXEC: begin
        // Fixed length keeps timing independent of the outcome
        if (cnt_r == `CBBX_EXEC_CYCLES - 2'h1) begin
          pc_we_nxt = 1'b1;
          pc_nxt = cond_r ? target : advanced;
          taken_nxt = cond_r;
          bit_we_nxt = is_bit_r && cond_r;
          state_nxt = CBBX_DONE;
        end
        cnt_nxt = 2'(cnt_r + 2'h1);
      end
      CBBX_DONE: begin
        state_nxt = CBBX_IDLE;
      end
      default: state_nxt = CBBX_IDLE;
    endcase
    // Registered so the status pin carries no decode glitch
    busy_nxt = (state_nxt != CBBX_IDLE);
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_r <= CBBX_IDLE;
      cnt_r <= 2'h0;
      is_bit_r <= 1'b0;
      cond_r <= 1'b0;
      disp_r <= 8'h00;
      baddr_r <= 8'h00;
      pc_base_r <= AW'(`CBBX_PC_RESET);
      pc_we_r <= 1'b0;
      pc_r <= AW'(`CBBX_PC_RESET);
      bit_we_r <= 1'b0;
      taken_r <= 1'b0;
      illegal_r <= 1'b0;
      psw_r <= 8'h00;
      busy_r <= 1'b0;
      bit_data_r <= 1'b0;
      psw_we_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      is_bit_r <= is_bit_nxt;
      cond_r <= cond_nxt;
      disp_r <= disp_nxt;
      baddr_r <= baddr_nxt;
      pc_base_r <= pc_base_nxt;
      pc_we_r <= pc_we_nxt;
      pc_r <= pc_nxt;
      bit_we_r <= bit_we_nxt;
      taken_r <= taken_nxt;
      illegal_r <= illegal_nxt;
      psw_r <= psw_nxt;
      busy_r <= busy_nxt;
      bit_data_r <= bit_data_nxt;
      psw_we_r <= psw_we_nxt;
    end
  end

  assign PC_WE_O = pc_we_r;
  assign PC_O = pc_r;
  assign BIT_WE_O = bit_we_r;
  assign BIT_ADDR_O = baddr_r;
  assign BIT_DATA_O = bit_data_r;
  assign PSW_WE_O = psw_we_r;
  assign PSW_O = psw_r;
  assign BUSY_O = busy_r;
  assign TAKEN_O = taken_r;
  assign ILLEGAL_O = illegal_r;

  a_pc_two_cycles: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && (is_bit_op || is_carry_op)) |-> !PC_WE_O ##1 !PC_WE_O ##1 PC_WE_O)
    else $error("Counter update not two cycles after issue");
  a_carry_taken: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && is_carry_op) |-> ##2 (TAKEN_O == $past(CARRY_I, 2)))
    else $error("Carry branch outcome does not follow carry");
  a_carry_target: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && is_carry_op) |-> ##2 (PC_O == AW'($past(PC_I, 2)
      + AW'(`CBBX_LEN_CARRY_BRANCH) + ($past(CARRY_I, 2)
      ? {{(AW-8){$past(DISP_I[7], 2)}}, $past(DISP_I, 2)} : AW'(0)))))
    else $error("Carry branch target wrong");
  a_bit_target: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && is_bit_op) |-> ##2 (PC_O == AW'($past(PC_I, 2)
      + AW'(`CBBX_LEN_BIT_BRANCH) + ($past(BIT_VAL_I, 2)
      ? {{(AW-8){$past(DISP_I[7], 2)}}, $past(DISP_I, 2)} : AW'(0)))))
    else $error("Bit branch target wrong");
  a_bit_clear: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && is_bit_op) |-> ##2 ((BIT_WE_O == $past(BIT_VAL_I, 2))
      && (BIT_ADDR_O == $past(BIT_ADDR_I, 2)) && !BIT_DATA_O))
    else $error("Bit clear write-back wrong");
  a_carry_no_bit: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && is_carry_op) |-> ##2 !BIT_WE_O)
    else $error("Carry branch wrote a bit");
  a_flags_kept: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    BUSY_O |-> !PSW_WE_O && (PSW_O == $past(PSW_I)))
    else $error("Flags disturbed by branch");
  a_decode_op: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && OPCODE_I == 8'h40) |=> BUSY_O ##1 BUSY_O ##1 !BUSY_O)
    else $error("Carry opcode not decoded");
  a_illegal_flag: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && !BUSY_O && !is_bit_op && !is_carry_op) |=> ILLEGAL_O && !BUSY_O)
    else $error("Unknown opcode not flagged");
  a_busy_ignore: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (START_I && BUSY_O) |=> !ILLEGAL_O)
    else $error("Start while busy was not ignored");
  a_pc_we_pulse: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    PC_WE_O |=> !PC_WE_O && !BIT_WE_O)
    else $error("Counter update strobe longer than one cycle");
  a_bit_we_pair: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    BIT_WE_O |-> PC_WE_O && !BIT_DATA_O)
    else $error("Bit write-back outside counter update");
endmodule // cbbx_exec

// >>> tb.sv
// Self-checking testbench for the conditional bit branch execution block
`timescale 1ns/1ns
`include "cbbx_params.svh"
module tb;
  import cbbx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic st = 1'b0;
  logic bv = 1'b0;
  logic cy = 1'b0;
  logic [7:0] op = 8'h00;
  logic [7:0] ba = 8'h00;
  logic [7:0] dp = 8'h00;
  logic [7:0] psw = 8'hA5;
  cbbx_addr_t addr = 16'h0000;
  logic a_we, b_we, b_d, f_we, busy, tkn, ill;
  logic [7:0] b_a, f_o;
  cbbx_addr_t a_o;
  int err_count = 0;
  int checks_done = 0;
  cbbx_exec #(.AW(16)) dut_u (.CORE_CLK_I(clk), .RST_I(rst), .START_I(st), .OPCODE_I(op),
    .BIT_ADDR_I(ba), .DISP_I(dp), .PC_I(addr), .BIT_VAL_I(bv), .CARRY_I(cy), .PSW_I(psw),
    .PC_WE_O(a_we), .PC_O(a_o), .BIT_WE_O(b_we), .BIT_ADDR_O(b_a), .BIT_DATA_O(b_d),
    .PSW_WE_O(f_we), .PSW_O(f_o), .BUSY_O(busy), .TAKEN_O(tkn), .ILLEGAL_O(ill));
  initial begin
    forever #4 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bit value and carry flip after issue: outcome must rest on values sampled at issue
  task issue(input logic [7:0] o, input logic [7:0] d, input cbbx_addr_t a, input logic b,
             input logic c);
    @(posedge clk);
    st <= 1'b1;
    op <= o;
    dp <= d;
    addr <= a;
    bv <= b;
    cy <= c;
    ba <= 8'h2A;
    @(posedge clk);
    st <= 1'b0;
    bv <= ~b;
    cy <= ~c;
    #1;
  endtask
  task answer;
    chk(busy, 1'b1);
    @(posedge clk);
    #1;
    chk(a_we, 1'b1);
  endtask
  task drain;
    @(posedge clk);
    #1;
    chk(a_we, 1'b0);
    @(posedge clk);
    #1;
    chk(busy, 1'b0);
  endtask
  task t_bit_set;
    issue(`CBBX_OP_BIT_BRANCH, 8'hF0, 16'h1000, 1'b1, 1'b0);
    answer;
    chk(a_o, 16'h0FF3);
    chk(b_we, 1'b1);
    chk(b_a, 8'h2A);
    chk(b_d, 1'b0);
    chk(tkn, 1'b1);
    drain;
  endtask
  task t_bit_clear;
    issue(`CBBX_OP_BIT_BRANCH, 8'h7F, 16'hFFFE, 1'b0, 1'b1);
    answer;
    chk(a_o, 16'h0001);
    chk(b_we, 1'b0);
    chk(tkn, 1'b0);
    drain;
  endtask
  task t_carry_set;
    issue(`CBBX_OP_CARRY_BRANCH, 8'h80, 16'h2000, 1'b0, 1'b1);
    answer;
    chk(a_o, 16'h1F82);
    chk(tkn, 1'b1);
    chk(b_we, 1'b0);
    chk(f_we, 1'b0);
    chk(f_o, 8'hA5);
    drain;
  endtask
  task t_carry_clear;
    issue(`CBBX_OP_CARRY_BRANCH, 8'h7F, 16'h2000, 1'b1, 1'b0);
    answer;
    chk(a_o, 16'h2002);
    chk(tkn, 1'b0);
    chk(f_we, 1'b0);
    drain;
  endtask
  task t_other_op;
    issue(8'h41, 8'h10, 16'h3000, 1'b1, 1'b1);
    chk(ill, 1'b1);
    chk(busy, 1'b0);
    @(posedge clk);
    #1;
    chk(a_we, 1'b0);
  endtask
  // Second start while busy must be dropped without any flag
  task t_refused;
    issue(`CBBX_OP_CARRY_BRANCH, 8'h10, 16'h4000, 1'b0, 1'b1);
    @(posedge clk);
    st <= 1'b1;
    op <= 8'h41;
    @(posedge clk);
    st <= 1'b0;
    #1;
    chk(ill, 1'b0);
    chk(busy, 1'b0);
    chk(a_o, 16'h4012);
  endtask
  // Reset in mid-instruction clears every output
  task t_reset;
    issue(`CBBX_OP_BIT_BRANCH, 8'h05, 16'h5000, 1'b1, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(busy, 1'b0);
    chk(a_o, 16'h0000);
    chk(b_we, 1'b0);
    chk(tkn, 1'b0);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_bit_set;
    t_bit_clear;
    t_carry_set;
    t_carry_clear;
    t_refused;
    t_reset;
    t_other_op;
    end_of_test;
  end
endmodule // tb
